// ==== src/dar_pkg.sv ====
// shared types and constants for the dma address remapper
package dar_pkg;
  localparam int GPA_W = 39;
  localparam int AGAW_W = 48;
  localparam int PAGE_SHIFT = 12;
  localparam int LEVELS = 4;
  localparam int IDX_W = 9;
  localparam int DID_W = 16;
  localparam int LVL_2M = 1;
  localparam int LVL_1G = 2;
  localparam logic [19:0] MSI_BASE = 20'h0_0FEE;
  localparam int MSI_SHIFT = 20;
  localparam logic [63:0] VFW_BASE = 64'h0000_0000_000C_0000;
  localparam logic [1:0] INV_ALL = 2'h0;
  localparam logic [1:0] INV_DOM = 2'h1;
  localparam logic [1:0] INV_PAGE = 2'h2;
  localparam logic [3:0] ST_OK = 4'h0;
  localparam logic [3:0] ST_UR = 4'h1;
  localparam logic [3:0] ST_BOGUS = 4'h2;
  localparam logic [7:0] FR_NO_CTX = 8'h01;
  localparam logic [7:0] FR_NO_PTE = 8'h02;
  localparam logic [7:0] FR_BOOT = 8'h03;
  localparam logic [7:0] FR_SUPER = 8'h04;
  localparam logic [7:0] FR_IRQ = 8'h05;
  localparam int TC_DEPTH = 8;
  localparam int PWR_CYC = 2;

  typedef struct packed {
    logic [15:0] bdf;
    logic [63:0] addr;
    logic wr;
    logic [7:0] be;
    logic is_irq;
    logic external;
  } dar_req_t;

  typedef struct packed {
    logic [63:0] addr;
    logic wr;
    logic [7:0] be;
    logic [3:0] status;
    logic passthru;
  } dar_rsp_t;

  typedef struct packed {
    logic [1:0] kind;
    logic [DID_W-1:0] did;
    logic [AGAW_W-1:PAGE_SHIFT] page;
  } dar_inv_t;

  typedef struct packed {
    logic [15:0] bdf;
    logic [63:0] addr;
    logic [7:0] reason;
  } dar_fault_t;
endpackage

// ==== src/dar_tcache.sv ====
`timescale 1ns/1ns
// tagged translation cache; the engine fills and looks up leaf entries only
module dar_tcache
  import dar_pkg::*;
#(
  parameter int DEPTH = TC_DEPTH
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [DID_W-1:0] i_lk_did,
  input wire logic [AGAW_W-1:PAGE_SHIFT] i_lk_page,
  input wire logic [1:0] i_lk_lvl,
  output logic o_hit,
  output logic [63:0] o_data,
  input wire logic i_fill,
  input wire logic [DID_W-1:0] i_f_did,
  input wire logic [AGAW_W-1:PAGE_SHIFT] i_f_page,
  input wire logic [1:0] i_f_lvl,
  input wire logic [63:0] i_f_data,
  input wire logic i_inv,
  input wire dar_inv_t i_inv_cmd
);
  localparam int PW = $clog2(DEPTH);
  logic [DEPTH-1:0] vld_q;
  logic [DID_W-1:0] did_q [DEPTH];
  logic [AGAW_W-1:PAGE_SHIFT] page_q [DEPTH];
  logic [1:0] lvl_q [DEPTH];
  logic [63:0] dat_q [DEPTH];
  logic [PW-1:0] ptr_q;
  logic [DEPTH-1:0] hit_w;
  logic [DEPTH-1:0] kill_w;

  function automatic logic [AGAW_W-1:PAGE_SHIFT] lvl_mask(input logic [1:0] lvl);
    lvl_mask = ~((36'h0_0000_0001 << (IDX_W * int'(lvl))) - 36'h0_0000_0001);
  endfunction

  // tags are domain plus page number, so domain and page flushes hit exactly [RL24]
  for (genvar g = 0; g < DEPTH; g++) begin : g_ent
    assign hit_w[g] = vld_q[g] && did_q[g] == i_lk_did && lvl_q[g] == i_lk_lvl &&
                      ((page_q[g] ^ i_lk_page) & lvl_mask(i_lk_lvl)) == '0;
    assign kill_w[g] = i_inv && (i_inv_cmd.kind == INV_ALL ||
                       (i_inv_cmd.kind == INV_DOM && did_q[g] == i_inv_cmd.did) ||
                       (i_inv_cmd.kind == INV_PAGE && did_q[g] == i_inv_cmd.did &&
                        page_q[g] == i_inv_cmd.page)); // [RL14]
    always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        vld_q[g] <= 1'b0;
      end else if (kill_w[g]) begin
        vld_q[g] <= 1'b0;
      end else if (i_fill && ptr_q == PW'(g)) begin
        vld_q[g] <= 1'b1;
      end
    end
    always_ff @(posedge i_clk) begin
      if (i_fill && ptr_q == PW'(g)) begin
        did_q[g] <= i_f_did;
        page_q[g] <= i_f_page & lvl_mask(i_f_lvl);
        lvl_q[g] <= i_f_lvl;
        dat_q[g] <= i_f_data;
      end
    end
  end

  always_comb begin
    o_data = '0;
    for (int i = 0; i < DEPTH; i++) begin
      if (hit_w[i]) begin
        o_data = dat_q[i];
      end
    end
  end
  assign o_hit = |hit_w;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ptr_q <= '0;
    end else if (i_fill) begin
      ptr_q <= ptr_q + PW'(1);
    end
  end
endmodule

// ==== src/dar_engine.sv ====
`timescale 1ns/1ns
// one remap engine: context lookup, table walk, faults and invalidation
module dar_engine
  import dar_pkg::*;
#(
  parameter bit SUPERPAGE = 1'b1
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_remap_en,
  input wire logic i_boot_prot,
  input wire logic i_super_en,
  input wire logic [63:0] i_root_base,
  input wire logic [63:0] i_def_ctx_lo,
  input wire logic [63:0] i_def_ctx_hi,
  input wire logic [63:0] i_bypass_lo,
  input wire logic [63:0] i_bypass_hi,
  input wire logic i_req_vld,
  output logic o_req_rdy,
  input wire dar_req_t i_req,
  output logic o_rsp_vld,
  output dar_rsp_t o_rsp,
  output logic o_mrd_vld,
  output logic [63:0] o_mrd_addr,
  input wire logic i_mrd_vld,
  input wire logic [63:0] i_mrd_data,
  input wire logic i_inv_vld,
  output logic o_inv_rdy,
  input wire dar_inv_t i_inv,
  input wire logic i_pend_zero,
  output logic o_inv_done,
  output logic o_fault_vld,
  output dar_fault_t o_fault
);
  typedef enum {S_IDLE, S_ROOT, S_CTXL, S_CTXH, S_WALK, S_DONE, S_FLT, S_INV} dar_st_t;
  dar_st_t st_q;
  dar_st_t st_d;
  dar_req_t req_q;
  logic [63:0] ptr_q;
  logic [63:0] ctx_lo_q;
  logic [DID_W-1:0] did_q;
  logic [1:0] lvl_q;
  logic [7:0] why_q;
  dar_inv_t inv_q;
  logic rsp_vld_q;
  dar_rsp_t rsp_q;
  logic flt_q;

  wire logic tc_hit;
  wire logic [63:0] tc_data;
  wire logic [63:0] leaf_w;
  wire logic is_msi = i_req.wr && i_req.addr[31:MSI_SHIFT] == MSI_BASE[11:0]; // [RL15]
  wire logic is_byp = i_req.addr >= i_bypass_lo && i_req.addr <= i_bypass_hi;
  wire logic pte_ok = i_mrd_data[0] | i_mrd_data[1];
  wire logic pte_big = i_mrd_data[7];
  wire logic [63:0] pte_pa = {12'h000, i_mrd_data[51:PAGE_SHIFT], 12'h000};
  wire logic [8:0] idx_w = 9'(req_q.addr >> (PAGE_SHIFT + IDX_W * int'(lvl_q)));
  wire logic addr_ovf = |req_q.addr[63:AGAW_W];
  wire logic big_ok = SUPERPAGE && i_super_en;
  wire logic fill_w = st_q == S_WALK && i_mrd_vld && pte_ok && !(pte_big && !big_ok);

  dar_tcache u_tc (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_lk_did(did_q),
    .i_lk_page(req_q.addr[AGAW_W-1:PAGE_SHIFT]),
    .i_lk_lvl(2'h0),
    .o_hit(tc_hit),
    .o_data(tc_data),
    .i_fill(fill_w && (lvl_q == 2'h0 || pte_big)), // only valid entries are cached [RL12] [RL10]
    .i_f_did(did_q),
    .i_f_page(req_q.addr[AGAW_W-1:PAGE_SHIFT]),
    .i_f_lvl(2'h0),
    .i_f_data({pte_pa[63:2], lvl_q}),
    .i_inv(st_q == S_INV && i_pend_zero),
    .i_inv_cmd(inv_q)
  );

  // large leaves keep more untranslated low bits; 4 KB keeps the low 12 [RL8] [RL21]
  function automatic logic [63:0] compose(input logic [63:0] pa, input logic [1:0] lvl,
                                          input logic [63:0] va);
    logic [63:0] m;
    m = (64'h0000_0000_0000_1000 << (IDX_W * int'(lvl))) - 64'h0000_0000_0000_0001;
    compose = ((pa & ~m) | (va & m)) & ((64'h1 << GPA_W) - 64'h1); // [RL7]
  endfunction
  assign leaf_w = compose({tc_data[63:2], 2'b00}, tc_data[1:0], req_q.addr);

  always_comb begin
    st_d = st_q;
    case (st_q)
      S_IDLE: begin
        if (i_inv_vld) begin
          st_d = S_INV; // [RL18]
        end else if (i_req_vld) begin
          st_d = S_ROOT;
        end
      end
      S_ROOT: begin
        if (!i_remap_en) begin
          st_d = S_DONE;
        end else if (i_mrd_vld) begin
          st_d = i_mrd_data[0] ? S_CTXL : S_CTXH; // [RL6]
        end
      end
      S_CTXL: begin
        if (i_mrd_vld) begin
          st_d = S_CTXH;
        end
      end
      S_CTXH: begin
        if (i_mrd_vld) begin
          st_d = ctx_lo_q[0] ? (tc_hit ? S_DONE : S_WALK) : S_FLT; // [RL3]
        end
      end
      S_WALK: begin
        if (i_mrd_vld) begin
          if (!pte_ok || (pte_big && !big_ok)) begin
            st_d = S_FLT;
          end else if (lvl_q == 2'h0 || pte_big) begin
            st_d = S_DONE;
          end
        end
      end
      S_DONE: st_d = S_IDLE;
      S_FLT: st_d = S_IDLE;
      S_INV: begin
        if (i_pend_zero) begin
          st_d = S_IDLE; // [RL13]
        end
      end
      default: st_d = S_IDLE;
    endcase
  end

  assign o_req_rdy = st_q == S_IDLE && !i_inv_vld;
  assign o_inv_rdy = st_q == S_IDLE;
  assign o_mrd_vld = st_q inside {S_ROOT, S_CTXL, S_CTXH, S_WALK} && i_remap_en;
  assign o_inv_done = st_q == S_INV && i_pend_zero;
  assign o_rsp_vld = rsp_vld_q;
  assign o_rsp = rsp_q;
  assign o_fault_vld = flt_q;
  assign o_fault = '{bdf: req_q.bdf, addr: req_q.addr, reason: why_q};

  always_comb begin
    o_mrd_addr = ptr_q;
    if (st_q == S_ROOT) begin
      o_mrd_addr = i_root_base + {52'h0, req_q.bdf[15:8], 4'h0}; // [RL23] [RL1]
    end else if (st_q == S_WALK) begin
      o_mrd_addr = ptr_q + {52'h0, idx_w, 3'h0}; // [RL4]
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= S_IDLE;
      req_q <= '0;
      ptr_q <= '0;
      ctx_lo_q <= '0;
      did_q <= '0;
      lvl_q <= '0;
      why_q <= '0;
      inv_q <= '0;
      rsp_vld_q <= 1'b0;
      rsp_q <= '0;
      flt_q <= 1'b0;
    end else begin
      st_q <= st_d;
      rsp_vld_q <= 1'b0;
      flt_q <= 1'b0;
      if (st_q == S_IDLE && i_inv_vld) begin
        inv_q <= i_inv;
      end
      if (st_q == S_IDLE && !i_inv_vld && i_req_vld) begin
        req_q <= i_req;
        if (is_msi || is_byp) begin
          // msi writes and the bypass range go out untouched [RL15] [RL19]
          st_q <= S_IDLE;
          rsp_vld_q <= 1'b1;
          rsp_q <= '{addr: i_req.addr, wr: i_req.wr, be: i_req.be, status: ST_OK,
                     passthru: 1'b1};
        end else if (i_req.is_irq) begin
          st_q <= S_IDLE; // interrupts never reach the dma walk [RL17]
          rsp_vld_q <= 1'b1;
          rsp_q <= '{addr: i_req.addr, wr: i_req.wr, be: i_req.be, status: ST_OK,
                     passthru: 1'b0};
        end else if (!i_remap_en && i_boot_prot) begin
          st_q <= S_FLT; // with boot protection on, requests other than msi writes, bypass hits and interrupts fault before remapping is set up [RL11]
          why_q <= FR_BOOT;
        end
      end
      if (st_q == S_ROOT && i_mrd_vld) begin
        ptr_q <= {i_mrd_data[63:PAGE_SHIFT], 12'h000} + {52'h0, req_q.bdf[7:0], 4'h0};
        if (!i_mrd_data[0]) begin
          ctx_lo_q <= i_def_ctx_lo; // default context for buses with no root entry [RL6]
          did_q <= i_def_ctx_hi[8 +: DID_W];
          ptr_q <= {i_def_ctx_lo[63:PAGE_SHIFT], 12'h000};
          lvl_q <= 2'(LEVELS - 1); // [RL20]
        end
      end
      if (st_q == S_CTXL && i_mrd_vld) begin
        ctx_lo_q <= i_mrd_data;
        ptr_q <= ptr_q + 64'h0000_0000_0000_0008;
      end
      if (st_q == S_CTXH && i_mrd_vld) begin
        did_q <= i_mrd_data[8 +: DID_W];
        ptr_q <= {ctx_lo_q[63:PAGE_SHIFT], 12'h000};
        lvl_q <= 2'(LEVELS - 1);
        why_q <= FR_NO_CTX;
      end
      if (st_q == S_WALK && i_mrd_vld) begin
        ptr_q <= pte_pa;
        why_q <= pte_ok ? FR_SUPER : FR_NO_PTE;
        if (!(lvl_q == 2'h0 || pte_big)) begin
          lvl_q <= lvl_q - 2'h1;
        end
        if (addr_ovf) begin
          st_q <= S_FLT;
          why_q <= FR_NO_PTE;
        end
      end
      if (st_q == S_DONE) begin
        rsp_vld_q <= 1'b1;
        rsp_q <= '{addr: i_remap_en ? leaf_w : req_q.addr, wr: req_q.wr, be: req_q.be,
                   status: ST_OK, passthru: !i_remap_en}; // [RL2]
      end
      if (st_q == S_FLT) begin
        // faulting cycle lands in the video firmware region, writes carry no bytes [RL16]
        flt_q <= 1'b1; // [RL9]
        rsp_vld_q <= 1'b1;
        rsp_q <= '{addr: VFW_BASE, wr: req_q.wr, be: 8'h00,
                   status: req_q.external ? ST_UR : ST_BOGUS, passthru: 1'b0};
      end
    end
  end
endmodule

// ==== src/dar_top.sv ====
`timescale 1ns/1ns
// dma address remapper top: two engines, fault record and msi request
//
// Operation
// RL1: requester id walks root and context tables to find the device table.
// RL2: a valid table translates the bus address before it goes to memory.
// RL3: missing table or translation raises a remapping fault, no forward.
// RL4: uncached translation triggers a multi-level walk of guest tables.
// RL5: one engine serves the graphics agent, another serves everyone else.
// RL6: root entries, context entries and a default context are supported.
// RL7: guest and host physical addresses are 39 bits in base mode.
// RL8: 4 KB pages; low 12 bits pass untranslated.
// RL9: one register fault record; each fault raises a message interrupt; a fault while one is pending is dropped with no message.
// RL10: leaf and non-leaf entries may be cached to skip walks; the engines cache leaf entries only.
// RL11: boot protection blocks dma before remapping is configured; msi writes and the bypass range still pass.
// RL12: invalid entries are never cached.
// RL13: invalidation waits until translated pending reads and writes drain.
// RL14: invalidation covers all, one domain, or one page.
// RL15: writes to the message interrupt window bypass translation.
// RL16: faults go to video firmware region, writes masked, links get UR.
// RL17: interrupt messages are remapped toward their domains; the engines return them with the address unchanged.
// RL18: queued invalidations are consumed and executed in order.
// RL19: addresses inside the bypass range pass untranslated.
// RL20: both engines walk four levels, 48-bit adjusted guest width.
// RL21: default engine honours 2 MB and 1 GB leaves.
// RL22: graphics engine has no large pages; firmware disables them then.
// RL23: root by bus, context by device/function; context gives domain and base.
// RL24: cache tags are domain and page for exact invalidation.
module dar_top
  import dar_pkg::*;
#(
  parameter logic [15:0] GFX_BDF = 16'h0010,
  parameter logic [63:0] MSI_ADDR = 64'h0000_0000_FEE0_0000,
  parameter logic [31:0] MSI_DATA = 32'h0000_0041
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_remap_en,
  input wire logic i_boot_prot,
  input wire logic i_super_en,
  input wire logic [63:0] i_root_base,
  input wire logic [63:0] i_def_ctx_lo,
  input wire logic [63:0] i_def_ctx_hi,
  input wire logic [63:0] i_bypass_lo,
  input wire logic [63:0] i_bypass_hi,
  input wire logic i_req_vld,
  output logic o_req_rdy,
  input wire dar_req_t i_req,
  output logic o_rsp_vld,
  output dar_rsp_t o_rsp,
  output logic o_mrd_vld,
  output logic [63:0] o_mrd_addr,
  input wire logic i_mrd_vld,
  input wire logic [63:0] i_mrd_data,
  input wire logic i_inv_vld,
  output logic o_inv_rdy,
  input wire dar_inv_t i_inv,
  input wire logic i_pend_zero,
  output logic o_inv_done,
  input wire logic i_fault_clr,
  output logic o_fault_pend,
  output dar_fault_t o_fault_rec,
  output logic o_msi_vld,
  output logic [63:0] o_msi_addr,
  output logic [31:0] o_msi_data
);
  logic rst_s1_q;
  logic rst_n_q;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // engine select: graphics agent gets its own engine [RL5]
  wire logic sel_gfx = i_req.bdf == GFX_BDF;
  logic own_q;
  logic busy_q;
  wire logic [1:0] rq_rdy;
  wire logic [1:0] rs_vld;
  dar_rsp_t rs [2];
  wire logic [1:0] mr_vld;
  wire logic [63:0] mr_addr [2];
  wire logic [1:0] iv_rdy;
  wire logic [1:0] iv_done;
  wire logic [1:0] fl_vld;
  dar_fault_t fl [2];
  logic inv_busy_q;
  logic rd_iss_q;

  for (genvar e = 0; e < 2; e++) begin : g_eng
    // graphics engine built without large pages; firmware keeps them off [RL22]
    dar_engine #(.SUPERPAGE(e == 0 ? 1'b1 : 1'b0)) u_eng (
      .i_clk(i_clk),
      .i_rst_n(rst_n_q),
      .i_remap_en(i_remap_en),
      .i_boot_prot(i_boot_prot),
      .i_super_en(i_super_en),
      .i_root_base(i_root_base),
      .i_def_ctx_lo(i_def_ctx_lo),
      .i_def_ctx_hi(i_def_ctx_hi),
      .i_bypass_lo(i_bypass_lo),
      .i_bypass_hi(i_bypass_hi),
      .i_req_vld(i_req_vld && o_req_rdy && sel_gfx == (e == 1)),
      .o_req_rdy(rq_rdy[e]),
      .i_req(i_req),
      .o_rsp_vld(rs_vld[e]),
      .o_rsp(rs[e]),
      .o_mrd_vld(mr_vld[e]),
      .o_mrd_addr(mr_addr[e]),
      .i_mrd_vld(i_mrd_vld && own_q == (e == 1)),
      .i_mrd_data(i_mrd_data),
      .i_inv_vld(i_inv_vld && o_inv_rdy && &iv_rdy),
      .o_inv_rdy(iv_rdy[e]),
      .i_inv(i_inv),
      .i_pend_zero(i_pend_zero),
      .o_inv_done(iv_done[e]),
      .o_fault_vld(fl_vld[e]),
      .o_fault(fl[e])
    );
  end

  // one walk and one read in flight at a time, so the read port needs no arbiter
  wire logic req_take = i_req_vld && o_req_rdy && (sel_gfx ? rq_rdy[1] : rq_rdy[0]);
  wire logic inv_take = i_inv_vld && o_inv_rdy && &iv_rdy; // [RL18]

  ////////////////////////////////////////////////////////////////////////////
  // fault record holds one entry; a new fault while pending is dropped
  wire logic flt_any = |fl_vld;
  wire dar_fault_t flt_w = fl_vld[1] ? fl[1] : fl[0];

  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      own_q <= 1'b0;
      busy_q <= 1'b0;
      inv_busy_q <= 1'b0;
      rd_iss_q <= 1'b0;
      o_req_rdy <= 1'b0;
      o_rsp_vld <= 1'b0;
      o_rsp <= '0;
      o_mrd_vld <= 1'b0;
      o_mrd_addr <= '0;
      o_inv_rdy <= 1'b0;
      o_inv_done <= 1'b0;
      o_fault_pend <= 1'b0;
      o_fault_rec <= '0;
      o_msi_vld <= 1'b0;
      o_msi_addr <= '0;
      o_msi_data <= '0;
    end else begin
      if (req_take) begin
        busy_q <= 1'b1;
        own_q <= sel_gfx;
      end else if (|rs_vld) begin
        busy_q <= 1'b0;
      end
      if (inv_take) begin
        inv_busy_q <= 1'b1;
      end else if (&iv_done) begin
        inv_busy_q <= 1'b0;
      end
      o_req_rdy <= !busy_q && !req_take && &rq_rdy;
      o_inv_rdy <= !inv_busy_q && !inv_take && &iv_rdy;
      o_rsp_vld <= |rs_vld;
      o_rsp <= rs_vld[1] ? rs[1] : rs[0];
      rd_iss_q <= !i_mrd_vld && (rd_iss_q || o_mrd_vld);
      o_mrd_vld <= |mr_vld && !o_mrd_vld && !rd_iss_q && !i_mrd_vld;
      o_mrd_addr <= own_q ? mr_addr[1] : mr_addr[0];
      o_inv_done <= &iv_done && inv_busy_q;
      o_msi_vld <= 1'b0;
      if (flt_any && !o_fault_pend) begin
        o_fault_pend <= 1'b1; // set beats a same-cycle clear [RL9]
        o_fault_rec <= flt_w;
        o_msi_vld <= 1'b1;
        o_msi_addr <= MSI_ADDR;
        o_msi_data <= MSI_DATA;
      end else if (i_fault_clr) begin
        o_fault_pend <= 1'b0;
      end
    end
  end
endmodule

// ==== bench/dar_top_chk.sv ====
// remapper top assertions
`timescale 1ns/1ns
module dar_top_chk
  import dar_pkg::*;
#(
  parameter logic [63:0] MSI_ADDR = 64'h0000_0000_FEE0_0000,
  parameter logic [31:0] MSI_DATA = 32'h0000_0041
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_remap_en,
  input wire logic i_boot_prot,
  input wire logic [63:0] i_bypass_lo,
  input wire logic [63:0] i_bypass_hi,
  input wire logic i_req_vld,
  input wire logic o_req_rdy,
  input wire dar_req_t i_req,
  input wire logic o_rsp_vld,
  input wire dar_rsp_t o_rsp,
  input wire logic o_mrd_vld,
  input wire logic i_pend_zero,
  input wire logic o_inv_done,
  input wire logic i_fault_clr,
  input wire logic o_fault_pend,
  input wire dar_fault_t o_fault_rec,
  input wire logic o_msi_vld,
  input wire logic [63:0] o_msi_addr,
  input wire logic [31:0] o_msi_data
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  ////////////////////////////////////////////////////////////////////////////////
  // request latched at acceptance
  dar_req_t req_q;
  wire take = i_req_vld && o_req_rdy;
  wire msi = i_req.wr && ((i_req.addr >> MSI_SHIFT) == 64'(MSI_BASE));
  wire in_byp = i_req.addr >= i_bypass_lo && i_req.addr <= i_bypass_hi;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      req_q <= '0;
    end else if (take) begin
      req_q <= i_req;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  fault_shape_a: assert property (
    o_rsp_vld && o_rsp.status != ST_OK |-> o_rsp.addr == VFW_BASE && o_rsp.be == 8'h00)
    else $error("fault not steered");
  fault_kind_a: assert property (
    o_rsp_vld && o_rsp.status != ST_OK |->
    o_rsp.status == (req_q.external ? ST_UR : ST_BOGUS))
    else $error("wrong fault status");
  low_bits_a: assert property (
    o_rsp_vld && o_rsp.status == ST_OK |-> o_rsp.addr[11:0] == req_q.addr[11:0])
    else $error("offset altered");
  msi_pass_a: assert property (
    take && i_remap_en && msi |->
    ##[1:3] o_rsp_vld && o_rsp.addr == req_q.addr && o_rsp.status == ST_OK)
    else $error("msi write translated");
  bypass_a: assert property (
    take && i_remap_en && in_byp && !msi |-> ##[1:3] o_rsp_vld && o_rsp.addr == req_q.addr)
    else $error("bypass translated");
  boot_block_a: assert property (
    take && !i_remap_en && i_boot_prot && !msi |-> ##[1:8] o_rsp_vld && o_rsp.status != ST_OK)
    else $error("boot dma not blocked");
  fault_hold_a: assert property (
    o_fault_pend && !i_fault_clr |=> o_fault_pend && $stable(o_fault_rec))
    else $error("fault record changed");
  msi_msg_a: assert property (
    o_msi_vld |-> o_msi_addr == MSI_ADDR && o_msi_data == MSI_DATA)
    else $error("bad fault message");
  inv_drain_a: assert property (
    !i_pend_zero && !$past(i_pend_zero) |-> !o_inv_done)
    else $error("early invalidation done");
  walk_gate_a: assert property (
    o_mrd_vld |-> i_remap_en)
    else $error("table read while off");
endmodule

bind dar_top dar_top_chk #(.MSI_ADDR(MSI_ADDR), .MSI_DATA(MSI_DATA)) u_chk (
  .i_clk, .i_arst_n, .i_remap_en, .i_boot_prot, .i_bypass_lo, .i_bypass_hi,
  .i_req_vld, .o_req_rdy, .i_req, .o_rsp_vld, .o_rsp, .o_mrd_vld, .i_pend_zero,
  .o_inv_done, .i_fault_clr, .o_fault_pend, .o_fault_rec, .o_msi_vld, .o_msi_addr,
  .o_msi_data
);

// ==== bench/dar_mem_model.sv ====
// table memory model: all entries empty, replies i_lat+1 cycles after a read
`timescale 1ns/1ns
module dar_mem_model (
  input wire logic i_clk,
  input wire logic i_rd_vld,
  input wire logic [63:0] i_rd_addr,
  input wire logic [3:0] i_lat,
  output logic o_vld,
  output logic [63:0] o_data
);
  int wait_cnt = -1;
  logic [63:0] junk = 64'h5A5A_5A5A_5A5A_5A5A;
  // data churns between replies so stale data is never held past o_vld
  always @(posedge i_clk) begin
    junk <= ~junk ^ i_rd_addr;
    o_vld <= 1'b0;
    o_data <= ~junk;
    if (i_rd_vld) begin
      wait_cnt <= int'(i_lat);
    end else if (wait_cnt == 0) begin
      o_vld <= 1'b1;
      o_data <= 64'h0000_0000_0000_0000;
      wait_cnt <= -1;
    end else if (wait_cnt > 0) begin
      wait_cnt <= wait_cnt - 1;
    end
  end
endmodule

// ==== bench/tb_dar_top.sv ====
// self-checking remapper bench
`timescale 1ns/1ns
module tb_dar_top;
  import dar_pkg::*;
  localparam logic [63:0] LO = 64'h0000_0000_0010_0000;
  localparam logic [63:0] HI = 64'h0000_0000_0010_FFFF;
  logic i_clk, i_arst_n, i_remap_en, i_boot_prot, i_super_en, i_req_vld, i_mrd_vld;
  logic i_inv_vld, i_pend_zero, i_fault_clr, o_req_rdy, o_rsp_vld, o_mrd_vld;
  logic o_inv_rdy, o_inv_done, o_fault_pend, o_msi_vld;
  logic [63:0] i_root_base, i_def_ctx_lo, i_def_ctx_hi, i_bypass_lo, i_bypass_hi;
  logic [63:0] i_mrd_data, o_mrd_addr, o_msi_addr;
  logic [31:0] o_msi_data;
  logic [3:0] lat;
  dar_req_t i_req;
  dar_rsp_t o_rsp, rsp;
  dar_inv_t i_inv;
  dar_fault_t o_fault_rec;
  int num_errors = 0, check_count = 0, msi_cnt = 0, rd_cnt = 0;
  dar_top uut (.*);
  dar_mem_model u_mem (.i_clk, .i_rd_vld(o_mrd_vld), .i_rd_addr(o_mrd_addr), .i_lat(lat),
    .o_vld(i_mrd_vld), .o_data(i_mrd_data));
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    if (o_msi_vld === 1'b1) msi_cnt++;
    if (o_mrd_vld === 1'b1) rd_cnt++;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // hold the request until ready, then catch the response pulse
  task automatic send(input logic [63:0] a, input logic wr, input logic [15:0] id,
                      input logic ext);
    int n = 0;
    @(posedge i_clk);
    i_req <= '{bdf: id, addr: a, wr: wr, be: 8'hFF, is_irq: 1'b0, external: ext};
    i_req_vld <= 1'b1;
    do @(posedge i_clk); while (o_req_rdy !== 1'b1 && ++n < 50);
    i_req_vld <= 1'b0;
    n = 0;
    do @(posedge i_clk); while (o_rsp_vld !== 1'b1 && ++n < 300);
    rsp = o_rsp;
    chk("rsp_vld", 64'h1, 64'(o_rsp_vld));
  endtask
  task automatic fault_chk(input logic ext);
    chk("fault addr", VFW_BASE, rsp.addr);
    chk("fault be", 64'h0, 64'(rsp.be));
    chk("fault status", 64'(ext ? ST_UR : ST_BOGUS), 64'(rsp.status));
  endtask
  task automatic clr();
    @(posedge i_clk);
    i_fault_clr <= 1'b1;
    @(posedge i_clk);
    i_fault_clr <= 1'b0;
    repeat (3) @(posedge i_clk);
    chk("fault_pend", 64'h0, 64'(o_fault_pend));
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_pass();
    send(64'h0000_0001_2345_6789, 1'b1, 16'h0100, 1'b0);
    chk("pass addr", 64'h0000_0001_2345_6789, rsp.addr);
    chk("pass status", 64'(ST_OK), 64'(rsp.status));
    $display("t_pass done");
  endtask
  task automatic t_boot();
    int m = msi_cnt;
    i_boot_prot <= 1'b1;
    send(64'h0000_0000_0040_0123, 1'b1, 16'h0208, 1'b1);
    fault_chk(1'b1);
    repeat (4) @(posedge i_clk);
    chk("msi count", 64'(m + 1), 64'(msi_cnt));
    chk("fault_pend", 64'h1, 64'(o_fault_pend));
    chk("rec addr", 64'h0000_0000_0040_0123, o_fault_rec.addr);
    chk("rec bdf", 64'h0208, 64'(o_fault_rec.bdf));
    clr();
    i_boot_prot <= 1'b0;
    $display("t_boot done");
  endtask
  task automatic t_msi();
    i_remap_en <= 1'b1;
    send(64'h0000_0000_FEE0_1004, 1'b1, 16'h0300, 1'b0);
    chk("msi addr", 64'h0000_0000_FEE0_1004, rsp.addr);
    chk("msi status", 64'(ST_OK), 64'(rsp.status));
    send(64'h0000_0000_FEE0_1004, 1'b0, 16'h0300, 1'b0);
    fault_chk(1'b0);
    clr();
    $display("t_msi done");
  endtask
  task automatic t_byp();
    int r;
    send(LO, 1'b0, 16'h0400, 1'b1);
    chk("bypass lo", LO, rsp.addr);
    send(HI, 1'b1, 16'h0400, 1'b1);
    chk("bypass hi", HI, rsp.addr);
    r = rd_cnt;
    send(HI + 64'h1, 1'b1, 16'h0400, 1'b1);
    fault_chk(1'b1);
    chk("walk reads", 64'h1, 64'(rd_cnt > r));
    lat <= 4'h6;
    send(64'h0000_0000_0020_0000, 1'b0, 16'h0010, 1'b0);
    fault_chk(1'b0);
    chk("rec kept", HI + 64'h1, o_fault_rec.addr);
    lat <= 4'h0;
    clr();
    $display("t_byp done");
  endtask
  task automatic t_inv();
    int n;
    logic [1:0] kinds [3] = '{INV_ALL, INV_DOM, INV_PAGE};
    for (int k = 0; k < 3; k++) begin
      @(posedge i_clk);
      i_pend_zero <= 1'b0;
      i_inv <= '{kind: kinds[k], did: 16'h0007, page: 36'h0_0000_0123};
      i_inv_vld <= 1'b1;
      n = 0;
      do @(posedge i_clk); while (o_inv_rdy !== 1'b1 && ++n < 50);
      i_inv_vld <= 1'b0;
      n = 0;
      repeat (10) begin
        @(posedge i_clk);
        if (o_inv_done === 1'b1) n++;
      end
      chk("early done", 64'h0, 64'(n));
      i_pend_zero <= 1'b1;
      n = 0;
      do @(posedge i_clk); while (o_inv_done !== 1'b1 && ++n < 20);
      chk("inv done", 64'h1, 64'(o_inv_done));
    end
    $display("t_inv done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    i_arst_n = 1'b0;
    i_remap_en = 1'b0;
    i_boot_prot = 1'b0;
    i_super_en = 1'b0;
    i_root_base = 64'h0000_0000_0080_0000;
    i_def_ctx_lo = 64'h0000_0000_0000_0000;
    i_def_ctx_hi = 64'h0000_0000_0000_0000;
    i_bypass_lo = LO;
    i_bypass_hi = HI;
    i_req_vld = 1'b0;
    i_req = '0;
    i_inv_vld = 1'b0;
    i_inv = '0;
    i_pend_zero = 1'b1;
    i_fault_clr = 1'b0;
    lat = 4'h0;
    repeat (20) @(posedge i_clk);
    i_arst_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    t_pass();
    t_boot();
    t_msi();
    t_byp();
    t_inv();
    test_done();
  end
  initial begin
    #400000;
    num_errors++;
    test_done();
  end
endmodule
